// ### verilog/wlsr_mode_pkg.sv
// shared constants and carrier types for the write latency / self refresh mode register
package wlsr_mode_pkg;

  // command bus widths
  localparam int unsigned ADDR_W      = 17;
  localparam int unsigned SEL_W       = 2;
  localparam logic [1:0]  SEL_THIS_REG = 2'h2;  // mode register select for this register

  // field positions inside the second_mode_register word
  localparam int unsigned CWL_LSB      = 3;
  localparam int unsigned CWL_MSB      = 5;
  localparam int unsigned ASR_BIT      = 6;
  localparam int unsigned SRT_BIT      = 7;
  localparam int unsigned RTTWR_LSB    = 9;
  localparam int unsigned RTTWR_MSB    = 10;

  // defined bits; everything else is reserved (16:11, 8, 2:0)
  localparam logic [16:0] DEFINED_MASK = 17'h006F8;

  // reset value of the stored word
  localparam logic [16:0] REG_RESET    = 17'h00000;

  // latency figures in clock cycles
  localparam int unsigned LAT_W        = 5;
  localparam logic [4:0]  CWL_BASE     = 5'h05;  // code 0 maps to this many cycles
  localparam int unsigned DELAY_DEPTH  = 32;     // pipe depth; the 5-bit total write delay reaches at most 31
  localparam logic [2:0]  BURST_CYCLES = 3'h4;   // eight data beats over four clocks

  // decoded mode settings
  typedef struct packed {
    logic [LAT_W-1:0] write_cas_delay;
    logic [LAT_W-1:0] total_write_delay;
    logic             auto_self_refresh;
    logic             forced_extended_temp_refresh;
    logic [1:0]       write_termination_value;
    logic             dyn_term_enable;
  } mode_fields_t;

  // termination in force on the data pins
  typedef struct packed {
    logic       use_write_value;
    logic [2:0] value;
  } term_select_t;

endpackage : wlsr_mode_pkg

// ### verilog/write_delay_line.sv
// delay line from write command to first data capture and burst window
`timescale 1ns/100ps
`default_nettype none
module write_delay_line (
  // clock and control
  input  wire logic                           ref_clk,
  input  wire logic                           sys_rst,
  input  wire logic                           clk_en,
  // write commands and delay
  input  wire logic                           write_cmd,
  input  wire logic [wlsr_mode_pkg::LAT_W-1:0] total_write_delay,
  // capture timing
  output logic                                data_capture,
  output logic                                burst_active
);
  import wlsr_mode_pkg::*;

  logic [DELAY_DEPTH-1:0] pipe_reg;
  logic [2:0]             burst_cnt_reg;
  logic [2:0]             burst_cnt_next;
  wire                    capture_now;

  // tap chosen by the decoded delay; a delay of zero comes out of the decode only when the sum wraps, and gives no capture
  assign capture_now    = (total_write_delay != 5'h00) && pipe_reg[total_write_delay - 5'h01];
  assign burst_cnt_next = capture_now ? BURST_CYCLES
                        : (burst_cnt_reg != 3'h0) ? burst_cnt_reg - 3'h1 : 3'h0;

  // one bit per cycle since each write; back to back writes ride side by side
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pipe_reg      <= '0;
      burst_cnt_reg <= 3'h0;
      data_capture  <= 1'b0;
      burst_active  <= 1'b0;
    end else if (clk_en) begin
      pipe_reg      <= {pipe_reg[DELAY_DEPTH-2:0], write_cmd};
      burst_cnt_reg <= burst_cnt_next;
      data_capture  <= capture_now;
      burst_active  <= burst_cnt_next != 3'h0;
    end
  end

endmodule : write_delay_line
`default_nettype wire

// ### verilog/write_latency_self_refresh_mode_reg.sv
// second mode register: write latency, self refresh rate and dynamic termination decode
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - load only by register_load_command; settings persist
// - reloading never touches the memory array
// - bits 5:3 select write_cas_delay
// - total delay is write_cas_delay plus additive
// - bit 6 enables auto_self_refresh
// - auto mode doubles rate above 85C
// - auto mode may double rate earlier
// - bit 7 enables forced_extended_temp_refresh
// - forced mode always doubles refresh rate
// - both off gives single refresh rate
// - bits 10:9 select write termination value
// - write value replaces nominal during burst
// - no dynamic termination during write leveling
module write_latency_self_refresh_mode_reg (
  // clock, reset, enable
  input  wire logic                             ref_clk,
  input  wire logic                             sys_rst,
  input  wire logic                             clk_en,
  // command bus
  input  wire logic                             register_load_command,
  input  wire logic [wlsr_mode_pkg::SEL_W-1:0]  mode_reg_select,
  input  wire logic [wlsr_mode_pkg::ADDR_W-1:0] cmd_addr,
  input  wire logic                             write_cmd,
  // settings held in other mode registers
  input  wire logic [wlsr_mode_pkg::LAT_W-1:0]  additive_latency,
  input  wire logic [2:0]                       nominal_termination_value,
  input  wire logic                             write_leveling,
  // temperature sensor flags, asynchronous
  input  wire logic                             temp_above_85_async,
  input  wire logic                             temp_near_85_async,
  // decoded settings
  output wlsr_mode_pkg::mode_fields_t           mode_cfg,
  output logic                                  self_refresh_double_rate,
  // write data timing and termination
  output logic                                  data_capture,
  output logic                                  write_burst_active,
  output wlsr_mode_pkg::term_select_t           term_select
);
  import wlsr_mode_pkg::*;

  logic [ADDR_W-1:0] second_mode_register_reg;
  logic [1:0]        hot_sync_reg;
  logic [1:0]        near_sync_reg;
  mode_fields_t      mode_next;
  term_select_t      term_next;
  logic              rate_next;

  wire               load_hit;
  wire [ADDR_W-1:0]  defined_bits;
  wire [2:0]         cwl_code;
  wire [LAT_W-1:0]   cwl_cycles;
  wire [LAT_W-1:0]   wl_cycles;
  wire               dyn_enable;
  wire               capture_int;
  wire               burst_int;

  // a load with another select value belongs to a different mode register
  assign load_hit     = register_load_command && (mode_reg_select == SEL_THIS_REG);
  assign defined_bits = second_mode_register_reg & DEFINED_MASK;

  // latency decode: code n gives base plus n cycles
  assign cwl_code   = defined_bits[CWL_MSB:CWL_LSB];
  assign cwl_cycles = CWL_BASE + {2'b00, cwl_code};
  assign wl_cycles  = cwl_cycles + additive_latency;

  // dynamic termination enabled by any nonzero value, never in leveling
  assign dyn_enable = (defined_bits[RTTWR_MSB:RTTWR_LSB] != 2'b00) && !write_leveling;

  // decoded field bundle
  always_comb begin
    mode_next                              = '0;
    mode_next.write_cas_delay              = cwl_cycles;
    mode_next.total_write_delay            = wl_cycles;
    mode_next.auto_self_refresh            = defined_bits[ASR_BIT];
    mode_next.forced_extended_temp_refresh = defined_bits[SRT_BIT];
    mode_next.write_termination_value      = defined_bits[RTTWR_MSB:RTTWR_LSB];
    mode_next.dyn_term_enable              = dyn_enable;
  end

  // refresh rate: forced wins outright, auto follows the sensor; if software sets both
  // the result is still double rate, the safe side for data retention
  always_comb begin
    rate_next = 1'b0;
    if (defined_bits[SRT_BIT]) begin
      rate_next = 1'b1;
    end else if (defined_bits[ASR_BIT]) begin
      rate_next = hot_sync_reg[1] | near_sync_reg[1];
    end
  end

  // termination: write value only inside a write burst with dynamic mode on
  always_comb begin
    term_next = '0;
    if (dyn_enable && burst_int) begin
      term_next.use_write_value = 1'b1;
      term_next.value           = {1'b0, defined_bits[RTTWR_MSB:RTTWR_LSB]};
    end else begin
      term_next.value           = nominal_termination_value;
    end
  end

  // mode word: only a matching load changes it; the array is never touched here
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      second_mode_register_reg <= REG_RESET;
    end else if (clk_en && load_hit) begin
      second_mode_register_reg <= cmd_addr;
    end
  end

  // sensor flags come from another domain, two flops before use
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      hot_sync_reg  <= 2'b00;
      near_sync_reg <= 2'b00;
    end else if (clk_en) begin
      hot_sync_reg  <= {hot_sync_reg[0], temp_above_85_async};
      near_sync_reg <= {near_sync_reg[0], temp_near_85_async};
    end
  end

  // registered outputs, one cycle behind the stored word
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      mode_cfg                 <= '0;
      self_refresh_double_rate <= 1'b0;
      term_select              <= '0;
    end else if (clk_en) begin
      mode_cfg                 <= mode_next;
      self_refresh_double_rate <= rate_next;
      term_select              <= term_next;
    end
  end

  assign data_capture       = capture_int;
  assign write_burst_active = burst_int;

  // capture delay line driven by the decoded total delay
  write_delay_line u_delay (
    .ref_clk           (ref_clk),
    .sys_rst           (sys_rst),
    .clk_en            (clk_en),
    .write_cmd         (write_cmd),
    .total_write_delay (wl_cycles),
    .data_capture      (capture_int),
    .burst_active      (burst_int)
  );

endmodule : write_latency_self_refresh_mode_reg
`default_nettype wire

// ### verification/wlsr_props.sv
// concurrent checks on the mode register decode and write timing
`timescale 1ns/100ps
`default_nettype none
module wlsr_props (
  // clock, reset, inputs
  input wire logic                       ref_clk,
  input wire logic                       sys_rst,
  input wire logic                       clk_en,
  input wire logic                       register_load_command,
  input wire logic [1:0]                 mode_reg_select,
  input wire logic [16:0]                cmd_addr,
  input wire logic [4:0]                 additive_latency,
  input wire logic                       temp_above_85_async,
  // outputs watched
  input wire wlsr_mode_pkg::mode_fields_t mode_cfg,
  input wire logic                       self_refresh_double_rate,
  input wire logic                       data_capture,
  input wire logic                       write_burst_active,
  input wire wlsr_mode_pkg::term_select_t term_select
);
  import wlsr_mode_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  // a low enable freezes every flop, so no timing holds across it
  default disable iff (sys_rst || !clk_en);
  // a load aimed at this register
  wire logic ld = register_load_command && mode_reg_select == SEL_THIS_REG;
  sequence s_burst; write_burst_active [*4]; endsequence
  sequence s_hot; temp_above_85_async [*4]; endsequence
  a_cwl_decode: assert property (ld |-> ##2
    mode_cfg.write_cas_delay == CWL_BASE + $past(cmd_addr[5:3], 2)) else $error("cas decode");
  a_refresh_bits: assert property (ld |-> ##2
    {mode_cfg.forced_extended_temp_refresh, mode_cfg.auto_self_refresh}
    == $past(cmd_addr[7:6], 2)) else $error("refresh bits");
  a_total_delay: assert property (!$past(sys_rst) && $stable(additive_latency) |->
    mode_cfg.total_write_delay == mode_cfg.write_cas_delay + additive_latency) else $error("wl");
  a_forced_double: assert property (mode_cfg.forced_extended_temp_refresh |->
    self_refresh_double_rate) else $error("forced rate");
  a_single_rate: assert property (!mode_cfg.forced_extended_temp_refresh &&
    !mode_cfg.auto_self_refresh |-> !self_refresh_double_rate) else $error("single rate");
  a_auto_double: assert property (s_hot ##0 mode_cfg.auto_self_refresh |->
    self_refresh_double_rate) else $error("auto rate");
  a_burst_window: assert property (data_capture |-> s_burst) else $error("burst");
  a_write_term: assert property ($past(write_burst_active) && mode_cfg.dyn_term_enable
    && $stable(mode_cfg) |-> term_select.use_write_value) else $error("write term");
endmodule : wlsr_props
bind write_latency_self_refresh_mode_reg wlsr_props wlsr_props_inst (.ref_clk, .sys_rst, .clk_en,
  .register_load_command, .mode_reg_select, .cmd_addr, .additive_latency,
  .temp_above_85_async, .mode_cfg, .self_refresh_double_rate, .data_capture,
  .write_burst_active, .term_select);
`default_nettype wire

// ### verification/ctl_model.sv
// controller model issuing register loads and write commands
`timescale 1ns/100ps
`default_nettype none
module ctl_model (
  // clock
  input  wire logic  ref_clk,
  // command bus
  output logic       register_load_command,
  output logic [1:0] mode_reg_select,
  output logic [16:0] cmd_addr,
  output logic       write_cmd
);
  import wlsr_mode_pkg::*;
  initial begin
    register_load_command = 1'b0;
    write_cmd = 1'b0;
    mode_reg_select = 2'h0;
    cmd_addr = 17'h00000;
  end
  // one load; callers keep idle banks and the gaps after it
  task automatic load(input logic [16:0] w, input logic [1:0] s);
    @(posedge ref_clk);
    #1;
    register_load_command = 1'b1;
    mode_reg_select = s;
    cmd_addr = w & DEFINED_MASK;
    if (w[SRT_BIT]) cmd_addr[ASR_BIT] = 1'b0;
    @(posedge ref_clk);
    #1;
    register_load_command = 1'b0;
    cmd_addr = ~cmd_addr; // released bus never shows the old word
    mode_reg_select = ~mode_reg_select;
  endtask : load
  // off-contract load with reserved bits left set, to show the decode ignores them
  task automatic load_raw(input logic [16:0] w);
    @(posedge ref_clk);
    #1;
    register_load_command = 1'b1;
    mode_reg_select = SEL_THIS_REG;
    cmd_addr = w;
    @(posedge ref_clk);
    #1;
    register_load_command = 1'b0;
    cmd_addr = ~cmd_addr;
    mode_reg_select = ~mode_reg_select;
  endtask : load_raw
  // single write command pulse
  task automatic write_one();
    @(posedge ref_clk);
    #1;
    write_cmd = 1'b1;
    @(posedge ref_clk);
    #1;
    write_cmd = 1'b0;
  endtask : write_one
endmodule : ctl_model
`default_nettype wire

// ### verification/tb.sv
// self-checking bench for the write latency and self refresh mode register
`timescale 1ns/100ps
`default_nettype none
module tb;
  import wlsr_mode_pkg::*;
  logic         ref_clk = 1'b0;
  logic         sys_rst = 1'b1;
  logic [4:0]   al = 5'h00;
  logic [2:0]   nom = 3'h0;
  logic         wlev = 1'b0;
  logic         hot = 1'b0;
  logic         near = 1'b0;
  logic         en = 1'b1;
  logic         ld, wr, dbl, cap, burst;
  logic [1:0]   sel;
  logic [16:0]  addr;
  mode_fields_t cfg;
  term_select_t term;
  int           n_errors = 0;
  int           checked = 0;
  logic [31:0]  rnd = 32'hE48D31C6;
  always #50 ref_clk = ~ref_clk;
  ctl_model ctl_model_inst (.ref_clk(ref_clk), .register_load_command(ld),
    .mode_reg_select(sel), .cmd_addr(addr), .write_cmd(wr));
  write_latency_self_refresh_mode_reg write_latency_self_refresh_mode_reg_inst (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(en), .register_load_command(ld),
    .mode_reg_select(sel), .cmd_addr(addr), .write_cmd(wr), .additive_latency(al),
    .nominal_termination_value(nom), .write_leveling(wlev), .temp_above_85_async(hot),
    .temp_near_85_async(near), .mode_cfg(cfg), .self_refresh_double_rate(dbl),
    .data_capture(cap), .write_burst_active(burst), .term_select(term));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  function automatic logic [4:0] exp_cwl(input int c);
    return CWL_BASE + 5'(c);
  endfunction : exp_cwl
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test
  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : settle
  // hang guard, about eight times the expected run
  initial begin
    settle(2000);
    n_errors++;
    finish_test();
  end
  initial begin
    logic [16:0] w;
    int n;
    settle(8);
    sys_rst = 1'b0;
    // every latency code with random fields and latencies
    for (int i = 0; i < 8; i++) begin
      rnd = xs(rnd);
      w = {rnd[16:6], 3'(i), rnd[2:0]};
      al = {2'h0, rnd[19:17]};
      nom = rnd[22:20];
      wlev = rnd[23];
      ctl_model_inst.load(w, SEL_THIS_REG);
      settle(3);
      check(cfg.write_cas_delay, exp_cwl(i));
      check(cfg.total_write_delay, exp_cwl(i) + al);
      check(cfg.forced_extended_temp_refresh, w[7]);
      check(cfg.auto_self_refresh, w[7] ? 1'b0 : w[6]);
      check(dbl, w[7]);
      check(cfg.write_termination_value, w[10:9]);
      check(cfg.dyn_term_enable, w[10:9] != 2'h0 && !wlev);
      ctl_model_inst.write_one();
      n = 0;
      while (cap !== 1'b1 && n < 40) begin
        settle(1);
        n++;
      end
      check(n, exp_cwl(i) + al);
      check(burst, 1'b1);
      settle(1);
      check(term.use_write_value, w[10:9] != 2'h0 && !wlev);
      check(term.value, (w[10:9] != 2'h0 && !wlev) ? {1'b0, w[10:9]} : nom);
      settle(4);
      check(burst, 1'b0);
      check(term, {1'b0, nom});
      $display("test %0d done", i);
    end
    // load to another register leaves settings alone
    ctl_model_inst.load(~w, 2'h1);
    settle(3);
    check(cfg.write_cas_delay, exp_cwl(7));
    // reserved bits 16, 13:11, 8 and 2:0 set around code 3 change nothing
    ctl_model_inst.load_raw(17'h1391F);
    settle(3);
    check(cfg.write_cas_delay, exp_cwl(3));
    check({cfg.forced_extended_temp_refresh, cfg.auto_self_refresh,
      cfg.write_termination_value}, 4'h0);
    // temperature driven rate switching, first with the enable frozen
    ctl_model_inst.load(17'h00040, SEL_THIS_REG);
    settle(3);
    en = 1'b0;
    hot = 1'b1;
    settle(5);
    check(dbl, 1'b0);
    en = 1'b1;
    settle(5);
    check(dbl, 1'b1);
    hot = 1'b0;
    near = 1'b1;
    settle(5);
    check(dbl, 1'b1);
    near = 1'b0;
    settle(5);
    check(dbl, 1'b0);
    ctl_model_inst.load(17'h000C0, SEL_THIS_REG);
    settle(3);
    check({cfg.auto_self_refresh, dbl}, 2'h1);
    $display("test temperature done");
    finish_test();
  end
endmodule : tb
`default_nettype wire
